/* hdl/sdirx_front_end.sv */
// Receiver front-end: mode, input choice, lock hunt, loop-through and host register port.
//
// Notes on behaviour
// - Master mode detects stream type automatically.
// - Slave mode retimes even non-conforming data.
// - Supports 1.485, 1.485/1.001 and 0.27 Gb/s.
// - Loop-through buffered or retimed, tristate, mutes.
// - Processing on after reset, each host-disableable.
// - Input choice high selects serial input one.
// - Input choice low selects serial input two.
// - Carrier taken from chosen input's valid pin.
// - Master hunts rate; slave follows rate select.
// - Loop-through muted while carrier is absent.
`timescale 1ns/100ps
`default_nettype none
`include "sdirx_defines.svh"

module sdirx_front_end #(
    parameter int HUNT_DWELL = `SDIRX_HUNT_DWELL_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic masterMode,
    input wire logic inputChoice,
    input wire logic serialInputOne,
    input wire logic serialInputTwo,
    input wire logic signalValidNOne,
    input wire logic signalValidNTwo,
    input wire logic rateSelect,
    input wire logic reclockSelectIn,
    input wire logic sdoEnable,
    input wire logic pllLock,
    input wire logic syncFound,
    input wire logic asiDetected,
    input wire logic retimedBit,
    input wire sdirx_pkg::sdirx_word_t errorFlagsIn,
    input wire sdirx_pkg::sdirx_word_t edhFlagsIn,
    input wire sdirx_pkg::sdirx_word_t videoStandardIn,
    input wire sdirx_pkg::sdirx_word_t formatLowIn,
    input wire sdirx_pkg::sdirx_word_t formatHighIn,
    input wire sdirx_pkg::sdirx_word_t wordsPerLineIn,
    input wire sdirx_pkg::sdirx_word_t linesPerFrameIn,
    input wire sdirx_pkg::sdirx_word_t activeWordsIn,
    input wire sdirx_pkg::sdirx_word_t activeLinesIn,
    input wire logic hostSclk,
    input wire logic hostCsN,
    input wire logic hostSdin,
    output logic selectedBit,
    output logic carrierPresent,
    output logic rateHd,
    output logic locked,
    output logic asiMode,
    output logic dataThrough,
    output logic reclockSelectOut,
    output logic reclockSelectOeN,
    output logic sdoData,
    output logic sdoOeN,
    output logic [`SDIRX_NUM_FEATURES-1:0] featureEnable,
    output logic hostSdout,
    output logic hostSdoutOeN
);
    import sdirx_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sdirx_lock_e lockState;
    logic [12:0] huntCount;
    logic [`SDIRX_NUM_FEATURES-1:0] procDisable;
    sdirx_word_t rxErrors;
    sdirx_word_t edhErrors;
    sdirx_word_t videoStd;
    sdirx_word_t fmtLow;
    sdirx_word_t fmtHigh;
    sdirx_word_t wordsLine;
    sdirx_word_t linesFrame;
    sdirx_word_t actWords;
    sdirx_word_t actLines;
    logic sclkLast;
    logic sclkRise;
    logic [5:0] bitCount;
    sdirx_word_t cmdShift;
    sdirx_word_t dataShift;
    sdirx_word_t outShift;
    logic cmdIsRead;
    sdirx_addr_t cmdAddr;
    logic rawCarrier;
    logic rawBit;
    logic reclockActive;
    logic next_sdoData;

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    // Any address outside the map reads as zero.
    function automatic sdirx_word_t regRead(input sdirx_addr_t addr);
        sdirx_word_t value;
        value = 16'h0000;
        case (addr)
            `SDIRX_ADDR_PROC_DISABLE: value = {9'h000, procDisable};
            `SDIRX_ADDR_RX_ERRORS: value = rxErrors;
            `SDIRX_ADDR_EDH_ERRORS: value = edhErrors;
            `SDIRX_ADDR_VIDEO_STD: value = videoStd;
            `SDIRX_ADDR_FMT_LOW: value = fmtLow;
            `SDIRX_ADDR_FMT_HIGH: value = fmtHigh;
            `SDIRX_ADDR_WORDS_LINE: value = wordsLine;
            `SDIRX_ADDR_LINES_FRAME: value = linesFrame;
            `SDIRX_ADDR_ACT_WORDS: value = actWords;
            `SDIRX_ADDR_ACT_LINES: value = actLines;
            default: value = 16'h0000;
        endcase
        return value;
    endfunction : regRead

    // The only writable location; every other address drops the write.
    function automatic logic isWritable(input sdirx_addr_t addr);
        return addr == `SDIRX_ADDR_PROC_DISABLE;
    endfunction : isWritable

    // ------------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------------
    // The valid pins are active low, so carrier is their inverse.
    assign rawBit = inputChoice ? serialInputOne : serialInputTwo;
    assign rawCarrier = inputChoice ? ~signalValidNOne : ~signalValidNTwo;

    // Registered copies feed the retimer and the lock hunt.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selectedBit <= 1'b0;
            carrierPresent <= 1'b0;
        end else begin
            selectedBit <= rawBit;
            carrierPresent <= rawCarrier;
        end
    end

    // ------------------------------------------------------------------
    // Lock detect and rate hunt
    // ------------------------------------------------------------------
    // In master mode the retimer centre toggles RATE_SELECT every dwell period
    // until the PLL locks and sync words are seen. Without carrier the
    // hunt restarts from SD, so a replugged cable locks quickly at 270 Mb/s.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lockState <= SDIRX_HUNT_SD;
            huntCount <= 13'h0000;
        end else if (!masterMode || !carrierPresent) begin
            lockState <= SDIRX_HUNT_SD;
            huntCount <= 13'h0000;
        end else begin
            case (lockState)
                SDIRX_HUNT_SD, SDIRX_HUNT_HD: begin
                    if (pllLock && syncFound) begin
                        lockState <= SDIRX_LOCKED;
                        huntCount <= 13'h0000;
                    end else if (huntCount == 13'(HUNT_DWELL - 1)) begin
                        huntCount <= 13'h0000;
                        lockState <= (lockState == SDIRX_HUNT_SD) ?
                            SDIRX_HUNT_HD : SDIRX_HUNT_SD;
                    end else begin
                        huntCount <= huntCount + 13'h0001;
                    end
                end
                SDIRX_LOCKED: begin
                    if (!pllLock || !syncFound) begin
                        lockState <= rateHd ? SDIRX_HUNT_HD : SDIRX_HUNT_SD;
                    end
                end
                default: lockState <= SDIRX_HUNT_SD;
            endcase
        end
    end

    // Rate follows the hunt in master mode, the rate pin in slave mode.
    // The HD setting covers both 1.485 and 1.485/1.001 Gb/s.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rateHd <= 1'b0;
        end else if (masterMode) begin
            rateHd <= (lockState == SDIRX_LOCKED) ? rateHd :
                      (lockState == SDIRX_HUNT_HD);
        end else begin
            rateHd <= rateSelect;
        end
    end

    // Slave mode reports analog lock only, so any data is retimed and
    // deserialized whether or not it carries sync words.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            locked <= 1'b0;
            asiMode <= 1'b0;
            dataThrough <= 1'b0;
        end else begin
            if (masterMode) begin
                locked <= carrierPresent && (lockState == SDIRX_LOCKED);
                asiMode <= asiDetected;
                dataThrough <= 1'b0;
            end else begin
                locked <= carrierPresent && pllLock;
                asiMode <= asiDetected;
                dataThrough <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Loop-through output
    // ------------------------------------------------------------------
    // The reclock pin is an output only in master mode; in slave mode the
    // host drives it and the enable releases it.
    assign reclockSelectOut = locked;
    assign reclockSelectOeN = ~masterMode;
    assign reclockActive = masterMode ? locked : reclockSelectIn;
    assign sdoOeN = ~sdoEnable;

    // Muting on lost carrier wins over every other choice; a retimed copy
    // without lock is muted too rather than sending garbage down the cable.
    always_comb begin
        if (!carrierPresent) begin
            next_sdoData = 1'b0;
        end else if (reclockActive) begin
            next_sdoData = locked ? retimedBit : 1'b0;
        end else begin
            next_sdoData = selectedBit;
        end
    end

    // Data outputs come from flip-flops; a tristated driver outputs zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdoData <= 1'b0;
        end else begin
            sdoData <= sdoEnable ? next_sdoData : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------------
    // Status registers track the processing core; no host access touches them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxErrors <= 16'h0000;
            edhErrors <= 16'h0000;
            videoStd <= 16'h0000;
            fmtLow <= 16'h0000;
            fmtHigh <= 16'h0000;
            wordsLine <= 16'h0000;
            linesFrame <= 16'h0000;
            actWords <= 16'h0000;
            actLines <= 16'h0000;
        end else begin
            rxErrors <= errorFlagsIn;
            edhErrors <= edhFlagsIn;
            videoStd <= videoStandardIn;
            fmtLow <= formatLowIn;
            fmtHigh <= formatHighIn;
            wordsLine <= wordsPerLineIn;
            linesFrame <= linesPerFrameIn;
            actWords <= activeWordsIn;
            actLines <= activeLinesIn;
        end
    end

    // ------------------------------------------------------------------
    // Host serial port
    // ------------------------------------------------------------------
    // The serial clock is sampled by the system clock, so it must run at
    // under a quarter of the system rate.
    assign sclkRise = hostSclk && !sclkLast && !hostCsN;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkLast <= 1'b0;
        end else begin
            sclkLast <= hostSclk;
        end
    end

    // Frame: 16 command bits then 16 data bits, MSB first.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCount <= 6'h00;
            cmdShift <= 16'h0000;
            dataShift <= 16'h0000;
        end else if (hostCsN) begin
            bitCount <= 6'h00;
        end else if (sclkRise && bitCount != `SDIRX_FRAME_BITS) begin
            bitCount <= bitCount + 6'h01;
            if (bitCount < `SDIRX_CMD_BITS) begin
                cmdShift <= {cmdShift[14:0], hostSdin};
            end else begin
                dataShift <= {dataShift[14:0], hostSdin};
            end
        end
    end

    assign cmdIsRead = cmdShift[`SDIRX_CMD_READ_BIT];
    assign cmdAddr = cmdShift[`SDIRX_CMD_ADDR_MSB:0];

    // Read data is loaded once the command is complete and then shifts out.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outShift <= 16'h0000;
        end else if (hostCsN) begin
            outShift <= 16'h0000;
        end else if (bitCount == `SDIRX_CMD_BITS && !sclkRise && cmdIsRead
                     && outShift == 16'h0000 && !sclkLast) begin
            outShift <= regRead(cmdAddr);
        end else if (sclkRise && bitCount >= `SDIRX_CMD_BITS) begin
            outShift <= {outShift[14:0], 1'b0};
        end
    end

    assign hostSdout = outShift[15];
    assign hostSdoutOeN = hostCsN || !cmdIsRead || bitCount < `SDIRX_CMD_BITS;

    // Processing features start enabled; a write sets disable bits.
    // Writes to status addresses fall through and change nothing.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            procDisable <= `SDIRX_PROC_DISABLE_RESET;
        end else if (sclkRise && bitCount == (`SDIRX_FRAME_BITS - 6'h01)
                     && !cmdIsRead && isWritable(cmdAddr)) begin
            procDisable <= {dataShift[5:0], hostSdin};
        end
    end

    // Each feature enable is the inverse of its own disable bit.
    genvar gi;
    generate
        for (gi = 0; gi < `SDIRX_NUM_FEATURES; gi++) begin : g_feat
            assign featureEnable[gi] = ~procDisable[gi];
        end
    endgenerate

endmodule : sdirx_front_end
`default_nettype wire

/* hdl/sdirx_defines.svh */
// Constants for the receiver front-end: offsets, fields, reset values and timing counts.
`ifndef SDIRX_DEFINES_SVH
`define SDIRX_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (12-bit word addresses on the host serial port)
// ----------------------------------------------------------------------
`define SDIRX_ADDR_PROC_DISABLE 12'h000
`define SDIRX_ADDR_RX_ERRORS 12'h001
`define SDIRX_ADDR_EDH_ERRORS 12'h003
`define SDIRX_ADDR_VIDEO_STD 12'h004
`define SDIRX_ADDR_FMT_LOW 12'h00c
`define SDIRX_ADDR_FMT_HIGH 12'h00d
`define SDIRX_ADDR_WORDS_LINE 12'h00e
`define SDIRX_ADDR_LINES_FRAME 12'h00f
`define SDIRX_ADDR_ACT_WORDS 12'h010
`define SDIRX_ADDR_ACT_LINES 12'h011

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SDIRX_NUM_FEATURES 7
`define SDIRX_PROC_DISABLE_RESET 7'h00
`define SDIRX_CMD_READ_BIT 15
`define SDIRX_CMD_ADDR_MSB 11
`define SDIRX_FRAME_BITS 6'h20
`define SDIRX_CMD_BITS 6'h10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SDIRX_CLK_PERIOD_NS 10
`define SDIRX_HUNT_DWELL_NS 10000
`define SDIRX_HUNT_DWELL_CYCLES (`SDIRX_HUNT_DWELL_NS / `SDIRX_CLK_PERIOD_NS)

`endif

/* hdl/sdirx_pkg.sv */
// Types shared by the receiver front-end.
package sdirx_pkg;

    // Lock-detect hunt states used in master operation.
    typedef enum logic [1:0] {
        SDIRX_HUNT_SD = 2'b00,
        SDIRX_HUNT_HD = 2'b01,
        SDIRX_LOCKED = 2'b10
    } sdirx_lock_e;

    typedef logic [15:0] sdirx_word_t;
    typedef logic [11:0] sdirx_addr_t;

endpackage : sdirx_pkg

/* dv/sdirx_front_end_assertions.sv */
// Port checker for the receiver front-end.
`timescale 1ns/100ps
`default_nettype none
`include "sdirx_defines.svh"

module sdirx_front_end_assertions #(
    parameter int HUNT_DWELL = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic masterMode,
    input wire logic inputChoice,
    input wire logic serialInputOne,
    input wire logic serialInputTwo,
    input wire logic signalValidNOne,
    input wire logic signalValidNTwo,
    input wire logic rateSelect,
    input wire logic hostCsN,
    input wire logic selectedBit,
    input wire logic carrierPresent,
    input wire logic rateHd,
    input wire logic locked,
    input wire logic sdoData,
    input wire logic [`SDIRX_NUM_FEATURES-1:0] featureEnable,
    input wire logic hostSdoutOeN
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    // One clock domain, so reset aborts every check in flight.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_pickOne; inputChoice |=> selectedBit == $past(serialInputOne); endproperty
    a_pickOne: assert property (p_pickOne) else $error("input one not chosen");
    property p_pickTwo; !inputChoice |=> selectedBit == $past(serialInputTwo); endproperty
    a_pickTwo: assert property (p_pickTwo) else $error("input two not chosen");
    property p_carrOne; inputChoice |=> carrierPresent != $past(signalValidNOne); endproperty
    a_carrOne: assert property (p_carrOne) else $error("carrier one wrong");
    property p_carrTwo; !inputChoice |=> carrierPresent != $past(signalValidNTwo); endproperty
    a_carrTwo: assert property (p_carrTwo) else $error("carrier two wrong");
    // Both samples must agree, since sdoData is registered and mutes one cycle after carrierPresent falls.
    property p_mute; !carrierPresent && !$past(carrierPresent) |-> !sdoData; endproperty
    a_mute: assert property (p_mute) else $error("output not muted");
    property p_featOn; $rose(rst_b) |-> featureEnable == 7'h7f; endproperty
    a_featOn: assert property (p_featOn) else $error("features off after reset");
    property p_slaveRate;
        !masterMode && !$past(masterMode) && $past(rst_b) |-> rateHd == $past(rateSelect);
    endproperty
    a_slaveRate: assert property (p_slaveRate) else $error("slave rate wrong");
    property p_lockHold;
        masterMode && $past(masterMode) && locked && $past(locked, 2) && carrierPresent
            && $past(carrierPresent) |-> $stable(rateHd);
    endproperty
    a_lockHold: assert property (p_lockHold) else $error("rate moved while locked");
    // The command phase never drives, so the first cycles of a frame stay released.
    property p_idleOut; $fell(hostCsN) |=> hostSdoutOeN[*8]; endproperty
    a_idleOut: assert property (p_idleOut) else $error("read driver on when idle");
endmodule : sdirx_front_end_assertions

bind sdirx_front_end sdirx_front_end_assertions #(.HUNT_DWELL(HUNT_DWELL)) i_chk (
    .clk, .rst_b, .masterMode, .inputChoice, .serialInputOne, .serialInputTwo,
    .signalValidNOne, .signalValidNTwo, .rateSelect, .hostCsN, .selectedBit,
    .carrierPresent, .rateHd, .locked, .sdoData, .featureEnable, .hostSdoutOeN
);
`default_nettype wire

/* dv/sdirx_equalizer_model.sv */
// Cable equalizer stand-in feeding both serial inputs and their valid flags.
`timescale 1ns/100ps
`default_nettype none

module sdirx_equalizer_model (
    input wire logic clk,
    input wire logic dropOne,
    input wire logic dropTwo,
    output logic serialInputOne,
    output logic serialInputTwo,
    output logic signalValidNOne,
    output logic signalValidNTwo
);
    logic [7:0] pattern = 8'h5b;
    logic lineOne = 1'b0;
    logic lineTwo = 1'b1;

    // A dead line toggles, so a stale bit can never pass for live data.
    always @(posedge clk) begin
        pattern <= {pattern[6:0], pattern[7] ^ pattern[5] ^ pattern[4] ^ pattern[3]};
        lineOne <= dropOne ? ~lineOne : pattern[0];
        lineTwo <= dropTwo ? ~lineTwo : pattern[4];
    end

    // The valid flags are active low: high marks an input as invalid.
    assign signalValidNOne = dropOne;
    assign signalValidNTwo = dropTwo;
    assign serialInputOne = lineOne;
    assign serialInputTwo = lineTwo;
endmodule : sdirx_equalizer_model
`default_nettype wire

/* dv/sdirx_front_end_test.sv */
// Self-checking bench for the receiver front-end.
`timescale 1ns/100ps
`default_nettype none
`include "sdirx_defines.svh"

module sdirx_front_end_test;
    import sdirx_pkg::*;
    localparam int DWELL = 8;
    logic clk = 1'b0, rst_b = 1'b0, masterMode = 1'b0, inputChoice = 1'b1;
    logic rateSelect = 1'b0, reclockSelectIn = 1'b0, sdoEnable = 1'b1, pllLock = 1'b0;
    logic syncFound = 1'b0, asiDetected = 1'b0, retimedBit = 1'b0, hostSclk = 1'b0;
    logic hostCsN = 1'b1, hostSdin = 1'b0, dropOne = 1'b0, dropTwo = 1'b0;
    logic serialInputOne, serialInputTwo, signalValidNOne, signalValidNTwo;
    logic selectedBit, carrierPresent, rateHd, locked, asiMode, dataThrough;
    logic reclockSelectOut, reclockSelectOeN, sdoData, sdoOeN, hostSdout, hostSdoutOeN;
    logic [`SDIRX_NUM_FEATURES-1:0] featureEnable;
    sdirx_word_t statusWord [9] = '{default: 16'h0000};
    sdirx_addr_t statusAddr [9] = '{`SDIRX_ADDR_RX_ERRORS, `SDIRX_ADDR_EDH_ERRORS,
        `SDIRX_ADDR_VIDEO_STD, `SDIRX_ADDR_FMT_LOW, `SDIRX_ADDR_FMT_HIGH,
        `SDIRX_ADDR_WORDS_LINE, `SDIRX_ADDR_LINES_FRAME, `SDIRX_ADDR_ACT_WORDS,
        `SDIRX_ADDR_ACT_LINES};
    sdirx_word_t rnd = 16'h003b;
    sdirx_word_t rd, wr;
    int n_checks = 0;
    int n_mismatch = 0;
    int toggles;

    sdirx_front_end #(.HUNT_DWELL(DWELL)) i_sdirx_front_end (
        .clk, .rst_b, .masterMode, .inputChoice, .serialInputOne, .serialInputTwo,
        .signalValidNOne, .signalValidNTwo, .rateSelect, .reclockSelectIn, .sdoEnable,
        .pllLock, .syncFound, .asiDetected, .retimedBit, .errorFlagsIn(statusWord[0]),
        .edhFlagsIn(statusWord[1]), .videoStandardIn(statusWord[2]),
        .formatLowIn(statusWord[3]), .formatHighIn(statusWord[4]),
        .wordsPerLineIn(statusWord[5]), .linesPerFrameIn(statusWord[6]),
        .activeWordsIn(statusWord[7]), .activeLinesIn(statusWord[8]), .hostSclk,
        .hostCsN, .hostSdin, .selectedBit, .carrierPresent, .rateHd, .locked, .asiMode,
        .dataThrough, .reclockSelectOut, .reclockSelectOeN, .sdoData, .sdoOeN,
        .featureEnable, .hostSdout, .hostSdoutOeN
    );

    sdirx_equalizer_model i_sdirx_equalizer_model (
        .clk, .dropOne, .dropTwo, .serialInputOne, .serialInputTwo,
        .signalValidNOne, .signalValidNTwo
    );

    // ------------------------------------------------------------
    // Clock, random sources and helpers
    // ------------------------------------------------------------
    // Clock at 100 MHz.
    always #5 clk = ~clk;

    // Next state of the stimulus shift register.
    function automatic sdirx_word_t lfsrNext(input sdirx_word_t s);
        return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
    endfunction : lfsrNext

    // Side inputs keep moving so the retimed and status paths see real traffic.
    always @(posedge clk) begin
        rnd <= lfsrNext(rnd);
        retimedBit <= rnd[3];
        reclockSelectIn <= rnd[7];
        asiDetected <= rnd[11];
    end

    function automatic sdirx_word_t expFeature(input sdirx_word_t dis);
        return {9'h000, ~dis[6:0]};
    endfunction : expFeature

    task automatic check(input string what, input sdirx_word_t exp, input sdirx_word_t got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // One 32-bit host frame; read bits are taken at the falling edge before each rise.
    task automatic hostFrame(input sdirx_word_t cmd, input sdirx_word_t dat,
                             output sdirx_word_t got);
        logic [31:0] frame;
        frame = {cmd, dat};
        got = 16'h0000;
        hostCsN <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            hostSclk <= 1'b0;
            hostSdin <= frame[i];
            repeat (2) @(posedge clk);
            @(negedge clk);
            got = {got[14:0], hostSdout};
            @(posedge clk);
            hostSclk <= 1'b1;
            repeat (2) @(posedge clk);
        end
        hostCsN <= 1'b1;
        hostSclk <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : hostFrame

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // A hang counts as a mismatch and still reaches the report.
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("featureEnable", 16'h007f, 16'(featureEnable));
        for (int i = 0; i < 8; i++) begin
            wr = (i < 7) ? (16'h0001 << i) : 16'h0005;
            hostFrame({4'h0, `SDIRX_ADDR_PROC_DISABLE}, wr, rd);
            check("featureEnable", expFeature(wr), 16'(featureEnable));
        end
        $display("test features done");
        for (int k = 0; k < 9; k++) begin
            statusWord[k] <= rnd;
            wr = rnd;
            hostFrame({4'h0, statusAddr[k]}, ~wr, rd);
            hostFrame({4'h8, statusAddr[k]}, 16'h0000, rd);
            check("statusRead", wr, rd);
        end
        hostFrame({4'h8, 12'h002}, 16'h0000, rd);
        check("unmappedRead", 16'h0000, rd);
        $display("test status done");
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            {sdoEnable, inputChoice, dropOne, dropTwo} <= c[3:0];
            settle(3);
            wr = 16'(inputChoice ? !dropOne : !dropTwo);
            check("carrierPresent", wr, 16'(carrierPresent));
            if (wr == 16'h0000) begin
                check("sdoData", 16'h0000, 16'(sdoData));
            end
            check("sdoOeN", 16'(!sdoEnable), 16'(sdoOeN));
        end
        $display("test input choice done");
        @(posedge clk);
        {sdoEnable, inputChoice, dropOne, dropTwo, pllLock} <= 5'b11001;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            rateSelect <= r[0];
            settle(3);
            check("rateHd", 16'(r[0]), 16'(rateHd));
        end
        check("slaveLocked", 16'h0001, 16'(locked));
        check("dataThrough", 16'h0001, 16'(dataThrough));
        check("reclockSelectOeN", 16'h0001, 16'(reclockSelectOeN));
        // Host picks retimed or buffered at random; with lock both paths pass data.
        for (int s = 0; s < 8; s++) begin
            wr[2:0] = {reclockSelectIn, retimedBit, selectedBit};
            @(negedge clk);
            check("sdoData", 16'(wr[2] ? wr[1] : wr[0]), 16'(sdoData));
        end
        $display("test slave done");
        @(posedge clk);
        {masterMode, pllLock} <= 2'b10;
        settle(2);
        toggles = 0;
        for (int t = 0; t < 4 * DWELL; t++) begin
            wr[0] = rateHd;
            @(negedge clk);
            toggles += int'(rateHd !== wr[0]);
        end
        check("huntToggles", 16'h0001, 16'(toggles >= 3 && toggles <= 4));
        @(posedge clk);
        {pllLock, syncFound} <= 2'b11;
        for (int t = 0; t < 8 && locked !== 1'b1; t++) begin
            settle(0);
        end
        check("masterLocked", 16'h0001, 16'(locked));
        check("retimedCopy", 16'h0001, 16'(reclockSelectOut));
        check("reclockSelectOeN", 16'h0000, 16'(reclockSelectOeN));
        check("dataThrough", 16'h0000, 16'(dataThrough));
        // Once locked in master mode the loop-through carries the retimed bit.
        for (int s = 0; s < 4; s++) begin
            wr[1:0] = {asiDetected, retimedBit};
            @(negedge clk);
            check("sdoData", 16'(wr[0]), 16'(sdoData));
            check("asiMode", 16'(wr[1]), 16'(asiMode));
        end
        settle(4);
        $display("test master done");
        test_done();
    end
endmodule : sdirx_front_end_test
`default_nettype wire
